// file: rtl/sar_port_pkg.sv
// shared constants for the converter host port
package sar_port_pkg;
	localparam int unsigned RESULT_WIDTH      = 16;
	localparam int unsigned BYTE_WIDTH        = 8;
	localparam int unsigned CLK_PERIOD_NS     = 40;
	localparam int unsigned CONV_MIN_LOW_NS   = 40;
	localparam int unsigned CONV_MIN_LOW_CYC  =
		(CONV_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CONV_CYCLES       = 60;
	localparam logic [15:0] RESULT_RESET      = 16'h0000;
	typedef enum logic [1:0] {TRACK, QUALIFY, CONVERT, UPDATE} port_state_type;
endpackage

// file: rtl/sar_result_reg.sv
// result holding register, loaded once per conversion
`timescale 1ns/10ps
module sar_result_reg #(
	parameter int unsigned WIDTH = 16
) (
	input  wire logic             sys_clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             load_in,
	input  wire logic [WIDTH-1:0] value_in,
	output logic      [WIDTH-1:0] held_out
);
	logic [WIDTH-1:0] held_reg;
	logic [WIDTH-1:0] held_next;

	always_comb
	begin
		held_next = held_reg;
		if (load_in)
		begin
			held_next = value_in;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			held_reg <= '0;
		end
		else
		begin
			held_reg <= held_next;
		end
	end

	assign held_out = held_reg;
endmodule

// file: rtl/sar_adc_parallel_port.sv
// parallel host port of a sampling converter
// How it works
// [R1] each result appears as one 16-bit parallel word
// [R2] results are binary twos complement, host reads them signed
// [R3] busy low from conversion start until result register updated
// [R4] byte select low gives top eight bits, high gives low eight
// [R5] chip select combined with read/convert; falling edge while low starts
// [R6] data outputs released when select high or read/convert low
// [R7] data bit 15 carries the most significant result bit
// [R8] host holds read/convert low at least 40 ns to start
// [R9] start when both inputs low, whichever fell first
// [R10] tracking resumes once a conversion completes
// [R11] result held stable for repeated reads until next conversion
`timescale 1ns/10ps
module sar_adc_parallel_port
	import sar_port_pkg::*;
#(
	parameter int unsigned CONV_CYCLES_P = sar_port_pkg::CONV_CYCLES
) (
	input  wire logic                                 sys_clk_in,
	input  wire logic                                 sys_rst_in,
	input  wire logic                                 chip_sel_n_in,
	input  wire logic                                 read_conv_n_in,
	input  wire logic                                 byte_sel_in,
	input  wire logic [sar_port_pkg::RESULT_WIDTH-1:0] sample_in,
	output logic                                      tracking_out,
	output logic                                      busy_n_out,
	output logic      [sar_port_pkg::RESULT_WIDTH-1:0] data_out,
	output logic      [sar_port_pkg::RESULT_WIDTH-1:0] data_oe_out
);
	import sar_port_pkg::*;

	// counter is eight bits wide
	if (CONV_CYCLES_P < 1 || CONV_CYCLES_P > 255)
	begin : g_bad_conv
		$error("conversion length out of range");
	end
	// minimum convert low time must fit the same counter
	if (CONV_MIN_LOW_CYC < 1 || CONV_MIN_LOW_CYC > 255)
	begin : g_bad_low
		$error("convert low time out of range");
	end
	// byte steering needs a word of exactly two bytes
	if (RESULT_WIDTH != 2 * BYTE_WIDTH)
	begin : g_bad_split
		$error("result must be two bytes");
	end
	// data path is laid out for a sixteen-bit word
	if (RESULT_WIDTH != 16)
	begin : g_bad_word
		$error("result must be sixteen bits");
	end

	port_state_type state_reg;
	port_state_type state_next;
	logic [7:0]  count_reg;
	logic [7:0]  count_next;
	logic        req_prev_reg;
	logic        req_prev_next;
	logic [15:0] sample_reg;
	logic [15:0] sample_next;
	logic [15:0] dout_reg;
	logic [15:0] dout_next;
	logic        load;
	logic        conv_req;
	logic [15:0] held;
	logic [15:0] word_src;
	logic [7:0]  lane_pick;
	logic        conv_start;
	logic        converting;
	logic        drive_en;

	// [R5] [R9] level combination of both lows
	assign conv_req = ~chip_sel_n_in & ~read_conv_n_in;

	// the host runs on its own timing: only a fresh low pair counts,
	// so a pair still low when a conversion ends never restarts it
	// [R5] fresh low pair
	assign conv_start = conv_req & ~req_prev_reg;

	always_comb
	begin
		state_next    = state_reg;
		count_next    = count_reg;
		sample_next   = sample_reg;
		req_prev_next = conv_req;
		load          = 1'b0;
		unique case (state_reg)
			TRACK:
			begin
				// [R5] new low combination starts
				if (conv_start)
				begin
					// [R8] low must persist the minimum time
					if (CONV_MIN_LOW_CYC <= 1)
					begin
						state_next  = CONVERT;
						sample_next = sample_in;
					end
					else
					begin
						state_next = QUALIFY;
					end
					count_next = 8'h01;
				end
			end
			QUALIFY:
			begin
				if (!conv_req)
				begin
					state_next = TRACK;
				end
				else if (count_reg + 8'h01 >= 8'(CONV_MIN_LOW_CYC))
				begin
					state_next  = CONVERT;
					sample_next = sample_in;
					count_next  = 8'h01;
				end
				else
				begin
					count_next = count_reg + 8'h01;
				end
			end
			CONVERT:
			begin
				// count out the conversion time
				if (count_reg >= 8'(CONV_CYCLES_P))
				begin
					state_next = UPDATE;
				end
				else
				begin
					count_next = count_reg + 8'h01;
				end
			end
			UPDATE:
			begin
				// [R11] capture result once per conversion
				load       = 1'b1;
				state_next = TRACK;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			// start in track with no pending edge
			state_reg    <= TRACK;
			count_reg    <= 8'h00;
			req_prev_reg <= 1'b1;
			sample_reg   <= RESULT_RESET;
		end
		else
		begin
			state_reg    <= state_next;
			count_reg    <= count_next;
			req_prev_reg <= req_prev_next;
			sample_reg   <= sample_next;
		end
	end

	// [R11] [R2] signed word stored unchanged
	sar_result_reg #(
		.WIDTH (RESULT_WIDTH)
	) result_hold (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.load_in    (load),
		.value_in   (sample_reg),
		.held_out   (held)
	);

	// [R3] output register loads with the result, so busy rises on fresh data
	assign word_src = load ? sample_reg : held;

	// [R4] low group pins pick top or bottom byte
	for (genvar lane = 0; lane < BYTE_WIDTH; lane++)
	begin : g_low_lane
		assign lane_pick[lane] = byte_sel_in ? word_src[lane] : word_src[lane + BYTE_WIDTH];
	end

	always_comb
	begin
		// [R1] [R7] full word, bit 15 on top
		dout_next = word_src;
		// [R4] byte steering onto low group
		dout_next[BYTE_WIDTH-1:0] = lane_pick;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			// pins read zero until the first result
			dout_reg <= RESULT_RESET;
		end
		else
		begin
			dout_reg <= dout_next;
		end
	end

	assign data_out = dout_reg;

	// [R6] drive only when selected and in read
	assign drive_en = ~chip_sel_n_in & read_conv_n_in;

	// [R6] one enable per data pin
	for (genvar pin = 0; pin < RESULT_WIDTH; pin++)
	begin : g_pin_oe
		assign data_oe_out[pin] = drive_en;
	end

	// sample held from start until the result register loads
	assign converting = (state_reg == CONVERT) || (state_reg == UPDATE);

	// [R3] busy low through conversion and update
	assign busy_n_out = ~converting;

	// [R10] tracking outside conversion
	assign tracking_out = ~converting;
endmodule

// file: sim/sar_port_chk.sv
// port checker for the converter host port
`timescale 1ns/10ps
module sar_port_chk #(
	parameter int unsigned CONV_CYCLES_P = 60
) (
	input wire logic        sys_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        chip_sel_n_in,
	input wire logic        read_conv_n_in,
	input wire logic        byte_sel_in,
	input wire logic [15:0] sample_in,
	input wire logic        tracking_out,
	input wire logic        busy_n_out,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe_out
);
	localparam int L = CONV_CYCLES_P + 3;
	wire req = ~chip_sel_n_in & ~read_conv_n_in;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	a_busy_start: assert property ($rose(req) && busy_n_out |-> ##[1:2] !busy_n_out)
		else $error("busy not lowered");
	a_busy_cause: assert property ($fell(busy_n_out) |-> $past(req) || $past(req, 2))
		else $error("busy without request");
	a_busy_hold: assert property ($fell(busy_n_out) |-> !busy_n_out[*3])
		else $error("busy too short");
	a_busy_end: assert property ($fell(busy_n_out) |-> ##[1:L] busy_n_out)
		else $error("busy stuck");
	a_oe_follow: assert property (data_oe_out == {16{~chip_sel_n_in & read_conv_n_in}})
		else $error("enable wrong");
	a_track_back: assert property ($rose(busy_n_out) |-> tracking_out)
		else $error("no tracking");
	a_hold_word: assert property (busy_n_out[*3] ##0 $stable(byte_sel_in)[*2]
		|-> $stable(data_out))
		else $error("word moved");
	a_msb_byte: assert property (busy_n_out[*3] ##0 !byte_sel_in[*2]
		|-> data_out[7:0] == data_out[15:8])
		else $error("byte wrong");
	a_top_byte: assert property (busy_n_out[*3] |-> $stable(data_out[15:8]))
		else $error("top byte moved");
	c_conv: cover property ($fell(busy_n_out));
	c_read: cover property (data_oe_out == 16'hffff);
	c_msb: cover property (busy_n_out && !byte_sel_in && data_oe_out[0]);
endmodule

// file: sim/sar_host_model.sv
// host model driving select and read/convert
`timescale 1ns/10ps
module sar_host_model (
	input  wire logic clk_in,
	input  wire logic go_in,
	input  wire logic rd_in,
	output logic      cs_n_out = 1'b1,
	output logic      rc_n_out = 1'b1
);
	// convert low one 40 ns cycle
	always @(negedge clk_in)
	begin
		cs_n_out <= ~(go_in | rd_in);
		rc_n_out <= ~go_in;
	end
endmodule

// file: sim/sar_adc_parallel_port_tb_top.sv
// bench for the converter host port
`timescale 1ns/10ps
module sar_adc_parallel_port_tb_top;
	logic        clk = 0, rst = 1, go = 0, rd = 0, bsel = 1, cs_n, rc_n, trk, busy_n;
	logic [15:0] smp = 16'h0000, dq, oe;
	int          n_mismatch = 0, n_checks = 0, cyc = 0;
	initial forever #20 clk = ~clk;
	sar_adc_parallel_port #(.CONV_CYCLES_P(3)) uut (.sys_clk_in(clk), .sys_rst_in(rst),
		.chip_sel_n_in(cs_n), .read_conv_n_in(rc_n), .byte_sel_in(bsel), .sample_in(smp),
		.tracking_out(trk), .busy_n_out(busy_n), .data_out(dq), .data_oe_out(oe));
	sar_host_model host (.clk_in(clk), .go_in(go), .rd_in(rd), .cs_n_out(cs_n),
		.rc_n_out(rc_n));
	task automatic chk(input string n, input logic [15:0] s, e);
		n_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_busy(input logic b);
		for (int k = 0; k < 300 && busy_n !== b; k++)
			@(negedge clk);
		chk("busy", busy_n, b);
		chk("track", trk, b);
	endtask
	task automatic conv(input logic [15:0] v);
		smp <= v;
		go <= 1'b1;
		@(negedge clk) go <= 1'b0;
		wait_busy(1'b0);
		smp <= ~v;
		wait_busy(1'b1);
		chk("fresh", dq, v);
	endtask
	task automatic t_word;
		conv(16'h8001);
		rd <= 1'b1;
		repeat (3) @(negedge clk);
		chk("word", dq, 16'h8001);
		chk("oe", oe, 16'hffff);
		rd <= 1'b0;
		repeat (2) @(negedge clk);
		chk("oe_off", oe, 16'h0000);
		$display("t_word done");
	endtask
	task automatic t_bytes;
		conv(16'h7f3c);
		rd <= 1'b1;
		bsel <= 1'b0;
		repeat (3) @(negedge clk);
		chk("msb", dq, 16'h7f7f);
		bsel <= 1'b1;
		repeat (2) @(negedge clk);
		chk("lsb", dq, 16'h7f3c);
		$display("t_bytes done");
	endtask
	task automatic t_refuse;
		smp <= 16'h0123;
		go <= 1'b1;
		@(negedge clk) go <= 1'b0;
		wait_busy(1'b0);
		// second request while the first is still converting
		go <= 1'b1;
		smp <= 16'hfedc;
		@(negedge clk) go <= 1'b0;
		wait_busy(1'b1);
		chk("fresh2", dq, 16'h0123);
		repeat (3) @(negedge clk);
		chk("idle", busy_n, 1'b1);
		chk("kept", dq, 16'h0123);
		$display("t_refuse done");
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			n_mismatch++;
			finish_test();
		end
	end
	initial
	begin
		repeat (20) @(negedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("rst_word", dq, 16'h0000);
		chk("rst_busy", busy_n, 1'b1);
		t_word();
		t_bytes();
		t_refuse();
		finish_test();
	end
endmodule
bind sar_adc_parallel_port sar_port_chk #(.CONV_CYCLES_P(CONV_CYCLES_P)) chk_i (.sys_clk_in,
	.sys_rst_in, .chip_sel_n_in, .read_conv_n_in, .byte_sel_in, .sample_in, .tracking_out,
	.busy_n_out, .data_out, .data_oe_out);
